// ---- core/sce_cfg.svh ----
// Error codes, function codes, register map and write value limits of the checker
`ifndef SCE_CFG_SVH
`define SCE_CFG_SVH

// ----------------------------------------------------------------
// Setup error codes
// ----------------------------------------------------------------
`define SCE_ERR_NONE 8'h00
`define SCE_ERR_ONE_BOTH 8'h01
`define SCE_ERR_TWO_BOTH 8'h02
`define SCE_ERR_DIFF_SINGLE 8'h03
`define SCE_ERR_COOLING_OUTPUT_MODE_CONFLICT 8'h04
`define SCE_ERR_UNIT_MISMATCH 8'h05
`define SCE_ERR_ALARM_NONE 8'h06
`define SCE_ERR_DWELL_BOTH 8'h07

// ----------------------------------------------------------------
// Communication error codes
// ----------------------------------------------------------------
`define SCE_ERR_BAD_FUNC 8'h0A
`define SCE_ERR_ADDR_RANGE 8'h0B
`define SCE_ERR_NO_PARAM 8'h0C
`define SCE_ERR_READ_ONLY 8'h0E
`define SCE_ERR_VALUE_RANGE 8'h0F

// ----------------------------------------------------------------
// Request decoding and register map
// ----------------------------------------------------------------
`define SCE_FC_READ 8'h03
`define SCE_FC_WRITE 8'h06
`define SCE_REG_COUNT 64
`define SCE_EXIST_MASK 64'h00FF_FFFF_FFFF_FFFF
`define SCE_RO_MASK 64'h00F0_0000_0000_000F
`define SCE_VAL_MIN 16'h0000
`define SCE_VAL_MAX 16'h270F
`define SCE_ZERO_16 16'h0000

`endif

// ---- core/sce_checker.sv ----
// Setup consistency checker with communication request error classifier
`timescale 1ns/10ps
`default_nettype none
`include "sce_cfg.svh"

module sce_checker #(
    parameter int REG_COUNT = `SCE_REG_COUNT,
    parameter logic [REG_COUNT-1:0] EXIST_MASK = `SCE_EXIST_MASK,
    parameter logic [REG_COUNT-1:0] RO_MASK = `SCE_RO_MASK,
    parameter logic [15:0] VAL_MIN = `SCE_VAL_MIN,
    parameter logic [15:0] VAL_MAX = `SCE_VAL_MAX
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire sce_pkg::sce_setup_s SETUP_I,
    input wire logic ALARM_TWO_ACTIVE_I,
    input wire sce_pkg::sce_comm_req_s COMM_REQ_I,
    input wire logic PARAM_LOCK_I,
    input wire logic COMM_ERR_CLR_I,
    output sce_pkg::sce_setup_err_s SETUP_ERR_O,
    output logic [7:0] SETUP_ERR_CODE_O,
    output logic OUTPUT_TWO_FUNCTION_ALARM_O,
    output sce_pkg::sce_comm_rsp_s COMM_RSP_O,
    output logic [7:0] COMM_LAST_ERR_O
);

    sce_pkg::sce_top_state_s q, d;

    // ----------------------------------------------------------------
    // Decoded selections
    // ----------------------------------------------------------------
    logic pv_diff;
    logic sp_single;
    logic pid_off;
    logic alarm_combined;
    logic units_differ;
    logic output_two_function_is_alarm;

    assign pv_diff = (SETUP_I.process_value_source == sce_pkg::PV_INPUT_ONE_MINUS_TWO)
        || (SETUP_I.process_value_source == sce_pkg::PV_INPUT_TWO_MINUS_ONE);
    assign sp_single = (SETUP_I.setpoint_source == sce_pkg::SP_INPUT_ONE_VALUE)
        || (SETUP_I.setpoint_source == sce_pkg::SP_INPUT_TWO_VALUE);
    // No PID when a band is zero and an integral time is zero
    assign pid_off = ((SETUP_I.proportional_band_one == `SCE_ZERO_16)
        || (SETUP_I.proportional_band_two == `SCE_ZERO_16))
        && ((SETUP_I.integral_time_one == `SCE_ZERO_16)
        || (SETUP_I.integral_time_two == `SCE_ZERO_16));
    assign alarm_combined = is_combined(SETUP_I.alarm_one_function)
        || is_combined(SETUP_I.alarm_two_function);
    assign units_differ = (SETUP_I.input_one_unit != SETUP_I.input_two_unit)
        || (SETUP_I.input_one_decimal_point != SETUP_I.input_two_decimal_point);
    assign output_two_function_is_alarm = (SETUP_I.output_two_function == sce_pkg::OUTPUT_TWO_FUNCTION_ALARM_TWO_OUTPUT_SELECT);

    function automatic logic is_combined(input sce_pkg::sce_alarm_fn_e fn);
        is_combined = (fn == sce_pkg::AL_COMBINED_PROCESS_HIGH_ALARM)
            || (fn == sce_pkg::AL_COMBINED_PROCESS_LOW_ALARM)
            || (fn == sce_pkg::AL_DIFFERENCE_HIGH_ALARM)
            || (fn == sce_pkg::AL_DIFFERENCE_LOW_ALARM);
    endfunction

    // ----------------------------------------------------------------
    // Consistency checks, rerun every cycle so a change shows next edge
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.err.one_both = (SETUP_I.process_value_source == sce_pkg::PV_INPUT_ONE_VALUE)
            && (SETUP_I.setpoint_source == sce_pkg::SP_INPUT_ONE_VALUE);
        d.err.two_both = (SETUP_I.process_value_source == sce_pkg::PV_INPUT_TWO_VALUE)
            && (SETUP_I.setpoint_source == sce_pkg::SP_INPUT_TWO_VALUE);
        d.err.diff_single = pv_diff && sp_single;
        d.err.cooling_output_mode_conflict = (SETUP_I.output_two_function == sce_pkg::OUTPUT_TWO_FUNCTION_COOLING_OUTPUT_MODE)
            && ((SETUP_I.output_one_function == sce_pkg::OUTPUT_ONE_FUNCTION_DIRECT_ACTION) || pid_off);
        d.err.unit_mismatch = units_differ && (pv_diff || sp_single || alarm_combined);
        d.err.alarm_none = output_two_function_is_alarm
            && (SETUP_I.alarm_two_function == sce_pkg::AL_NONE);
        d.err.dwell_both = (SETUP_I.alarm_one_function == sce_pkg::AL_DWELL_TIMER_FUNCTION)
            && (SETUP_I.alarm_two_function == sce_pkg::AL_DWELL_TIMER_FUNCTION);
        // Only the lowest code is shown; the flag vector keeps the full picture
        if (d.err.one_both) begin
            d.code = `SCE_ERR_ONE_BOTH;
        end else if (d.err.two_both) begin
            d.code = `SCE_ERR_TWO_BOTH;
        end else if (d.err.diff_single) begin
            d.code = `SCE_ERR_DIFF_SINGLE;
        end else if (d.err.cooling_output_mode_conflict) begin
            d.code = `SCE_ERR_COOLING_OUTPUT_MODE_CONFLICT;
        end else if (d.err.unit_mismatch) begin
            d.code = `SCE_ERR_UNIT_MISMATCH;
        end else if (d.err.alarm_none) begin
            d.code = `SCE_ERR_ALARM_NONE;
        end else if (d.err.dwell_both) begin
            d.code = `SCE_ERR_DWELL_BOTH;
        end else begin
            d.code = `SCE_ERR_NONE;
        end
        // Alarm two drives output two only with a real alarm function
        d.output_two_function_alarm = output_two_function_is_alarm && ALARM_TWO_ACTIVE_I
            && (SETUP_I.alarm_two_function != sce_pkg::AL_NONE);
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign SETUP_ERR_O = q.err;
    assign SETUP_ERR_CODE_O = q.code;
    assign OUTPUT_TWO_FUNCTION_ALARM_O = q.output_two_function_alarm;

    // ----------------------------------------------------------------
    // Communication side
    // ----------------------------------------------------------------
    // The master is expected to stay within the map; anything else is coded, not trusted
    sce_comm_check #(
        .REG_COUNT(REG_COUNT),
        .EXIST_MASK(EXIST_MASK),
        .RO_MASK(RO_MASK),
        .VAL_MIN(VAL_MIN),
        .VAL_MAX(VAL_MAX)
    ) u_comm (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .req_i(COMM_REQ_I),
        .lock_i(PARAM_LOCK_I),
        .err_clr_i(COMM_ERR_CLR_I),
        .rsp_o(COMM_RSP_O),
        .last_err_o(COMM_LAST_ERR_O)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);

    property p_one_both;
        SETUP_I.process_value_source == sce_pkg::PV_INPUT_ONE_VALUE
            && SETUP_I.setpoint_source == sce_pkg::SP_INPUT_ONE_VALUE
            |=> SETUP_ERR_O.one_both && SETUP_ERR_CODE_O == `SCE_ERR_ONE_BOTH;
    endproperty
    a_one_both: assert property (p_one_both) else $error("code 1 missing");

    property p_two_both;
        SETUP_I.process_value_source == sce_pkg::PV_INPUT_TWO_VALUE
            && SETUP_I.setpoint_source == sce_pkg::SP_INPUT_TWO_VALUE
            |=> SETUP_ERR_O.two_both && SETUP_ERR_CODE_O == `SCE_ERR_TWO_BOTH;
    endproperty
    a_two_both: assert property (p_two_both) else $error("code 2 missing");

    property p_diff_single;
        pv_diff && sp_single |=> SETUP_ERR_O.diff_single && SETUP_ERR_CODE_O <= `SCE_ERR_DIFF_SINGLE;
    endproperty
    a_diff_single: assert property (p_diff_single) else $error("code 3 missing");

    property p_cooling_output_mode;
        SETUP_ERR_O.cooling_output_mode_conflict |-> $past(SETUP_I.output_two_function) == sce_pkg::OUTPUT_TWO_FUNCTION_COOLING_OUTPUT_MODE;
    endproperty
    a_cooling_output_mode: assert property (p_cooling_output_mode) else $error("code 4 without cooling output");

    property p_cooling_output_mode_direct;
        SETUP_I.output_two_function == sce_pkg::OUTPUT_TWO_FUNCTION_COOLING_OUTPUT_MODE
            && SETUP_I.output_one_function == sce_pkg::OUTPUT_ONE_FUNCTION_DIRECT_ACTION |=> SETUP_ERR_O.cooling_output_mode_conflict;
    endproperty
    a_cooling_output_mode_direct: assert property (p_cooling_output_mode_direct) else $error("code 4 missing for direct action");

    property p_units;
        SETUP_ERR_O.unit_mismatch |-> $past(units_differ);
    endproperty
    a_units: assert property (p_units) else $error("code 5 with matching units");

    property p_alarm_none;
        output_two_function_is_alarm && SETUP_I.alarm_two_function == sce_pkg::AL_NONE
            |=> SETUP_ERR_O.alarm_none && !OUTPUT_TWO_FUNCTION_ALARM_O;
    endproperty
    a_alarm_none: assert property (p_alarm_none) else $error("code 6 or alarm action wrong");

    property p_output_two_function_quiet;
        OUTPUT_TWO_FUNCTION_ALARM_O |-> $past(SETUP_I.alarm_two_function) != sce_pkg::AL_NONE && !SETUP_ERR_O.alarm_none;
    endproperty
    a_output_two_function_quiet: assert property (p_output_two_function_quiet) else $error("alarm action with no function");

    property p_dwell;
        SETUP_I.alarm_one_function == sce_pkg::AL_DWELL_TIMER_FUNCTION
            && SETUP_I.alarm_two_function == sce_pkg::AL_DWELL_TIMER_FUNCTION |=> SETUP_ERR_O.dwell_both;
    endproperty
    a_dwell: assert property (p_dwell) else $error("code 7 missing");

    sequence s_stable_clean;
        $stable(SETUP_I) && !pv_diff && !sp_single && !alarm_combined && !output_two_function_is_alarm
            && SETUP_I.output_two_function != sce_pkg::OUTPUT_TWO_FUNCTION_COOLING_OUTPUT_MODE
            && SETUP_I.alarm_two_function != sce_pkg::AL_DWELL_TIMER_FUNCTION
            && SETUP_I.process_value_source != sce_pkg::PV_INPUT_ONE_VALUE;
    endsequence

    property p_clear;
        s_stable_clean [*2] |=> SETUP_ERR_CODE_O == `SCE_ERR_NONE && SETUP_ERR_O == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("error held after conflict removed");

endmodule
`default_nettype wire

// ---- core/sce_comm_check.sv ----
// Classifier of remote register requests into communication error codes
`timescale 1ns/10ps
`default_nettype none
`include "sce_cfg.svh"

module sce_comm_check #(
    parameter int REG_COUNT = `SCE_REG_COUNT,
    parameter logic [REG_COUNT-1:0] EXIST_MASK = `SCE_EXIST_MASK,
    parameter logic [REG_COUNT-1:0] RO_MASK = `SCE_RO_MASK,
    parameter logic [15:0] VAL_MIN = `SCE_VAL_MIN,
    parameter logic [15:0] VAL_MAX = `SCE_VAL_MAX
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire sce_pkg::sce_comm_req_s req_i,
    input wire logic lock_i,
    input wire logic err_clr_i,
    output sce_pkg::sce_comm_rsp_s rsp_o,
    output logic [7:0] last_err_o
);

    localparam int IDX_W = $clog2(REG_COUNT);

    sce_pkg::sce_comm_state_s q, d;
    logic is_read;
    logic is_write;
    logic [IDX_W-1:0] idx;

    assign is_read = (req_i.func == `SCE_FC_READ);
    assign is_write = (req_i.func == `SCE_FC_WRITE);
    assign idx = req_i.addr[IDX_W-1:0];

    // ----------------------------------------------------------------
    // Classification, first failing check wins
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.rsp.valid = req_i.valid;
        d.rsp.wr_en = 1'b0;
        d.rsp.err = `SCE_ERR_NONE;
        if (!is_read && !is_write) begin
            d.rsp.err = `SCE_ERR_BAD_FUNC;
        end else if (req_i.addr >= 16'(REG_COUNT)) begin
            d.rsp.err = `SCE_ERR_ADDR_RANGE;
        end else if (!EXIST_MASK[idx]) begin
            d.rsp.err = `SCE_ERR_NO_PARAM;
        end else if (is_write && (RO_MASK[idx] || lock_i)) begin
            d.rsp.err = `SCE_ERR_READ_ONLY;
        end else if (is_write && (req_i.data < VAL_MIN || req_i.data > VAL_MAX)) begin
            d.rsp.err = `SCE_ERR_VALUE_RANGE;
        end
        if (!req_i.valid) begin
            d.rsp.err = `SCE_ERR_NONE;
        end
        // Refused writes never reach the parameter store
        d.rsp.wr_en = req_i.valid && is_write && (d.rsp.err == `SCE_ERR_NONE);
        d.rsp.wr_addr = req_i.addr;
        d.rsp.wr_data = req_i.data;
        // A new error outranks a clear in the same cycle
        if (err_clr_i) begin
            d.last_err = `SCE_ERR_NONE;
        end
        if (d.rsp.err != `SCE_ERR_NONE) begin
            d.last_err = d.rsp.err;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rsp_o = q.rsp;
    assign last_err_o = q.last_err;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sequence s_bad_func;
        req_i.valid && !is_read && !is_write;
    endsequence

    sequence s_write_locked;
        req_i.valid && is_write && req_i.addr < 16'(REG_COUNT) && EXIST_MASK[idx] && (RO_MASK[idx] || lock_i);
    endsequence

    property p_bad_func;
        s_bad_func |=> rsp_o.valid && rsp_o.err == `SCE_ERR_BAD_FUNC && !rsp_o.wr_en;
    endproperty
    a_bad_func: assert property (p_bad_func) else $error("bad function code not flagged");

    property p_addr_range;
        req_i.valid && (is_read || is_write) && req_i.addr >= 16'(REG_COUNT)
            |=> rsp_o.err == `SCE_ERR_ADDR_RANGE && !rsp_o.wr_en;
    endproperty
    a_addr_range: assert property (p_addr_range) else $error("address range error not flagged");

    property p_no_param;
        req_i.valid && (is_read || is_write) && req_i.addr < 16'(REG_COUNT) && !EXIST_MASK[idx]
            |=> rsp_o.err == `SCE_ERR_NO_PARAM;
    endproperty
    a_no_param: assert property (p_no_param) else $error("missing parameter not flagged");

    property p_read_only;
        s_write_locked |=> rsp_o.valid && rsp_o.err == `SCE_ERR_READ_ONLY && !rsp_o.wr_en;
    endproperty
    a_read_only: assert property (p_read_only) else $error("protected write not refused");

    property p_value_range;
        rsp_o.wr_en |-> $past(req_i.data) >= VAL_MIN && $past(req_i.data) <= VAL_MAX && rsp_o.err == `SCE_ERR_NONE;
    endproperty
    a_value_range: assert property (p_value_range) else $error("out of range value written");

    property p_last_err;
        rsp_o.valid && rsp_o.err != `SCE_ERR_NONE |-> last_err_o == rsp_o.err;
    endproperty
    a_last_err: assert property (p_last_err) else $error("last error not captured");

endmodule
`default_nettype wire

// ---- core/sce_pkg.sv ----
// Types shared by the setup and communication error checker
package sce_pkg;

    // ----------------------------------------------------------------
    // Setup selections
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PV_INPUT_ONE_VALUE = 2'b00,
        PV_INPUT_TWO_VALUE = 2'b01,
        PV_INPUT_ONE_MINUS_TWO = 2'b10,
        PV_INPUT_TWO_MINUS_ONE = 2'b11
    } sce_pv_src_e;

    typedef enum logic [1:0] {
        SP_LOCAL = 2'b00,
        SP_INPUT_ONE_VALUE = 2'b01,
        SP_INPUT_TWO_VALUE = 2'b10,
        SP_OTHER = 2'b11
    } sce_sp_src_e;

    typedef enum logic {
        OUTPUT_ONE_FUNCTION_REVERSE_ACTION = 1'b0,
        OUTPUT_ONE_FUNCTION_DIRECT_ACTION = 1'b1
    } sce_output_one_function_fn_e;

    typedef enum logic [1:0] {
        OUTPUT_TWO_FUNCTION_NONE = 2'b00,
        OUTPUT_TWO_FUNCTION_COOLING_OUTPUT_MODE = 2'b01,
        OUTPUT_TWO_FUNCTION_ALARM_TWO_OUTPUT_SELECT = 2'b10,
        OUTPUT_TWO_FUNCTION_OTHER = 2'b11
    } sce_output_two_function_fn_e;

    typedef enum logic [2:0] {
        AL_NONE = 3'b000,
        AL_DWELL_TIMER_FUNCTION = 3'b001,
        AL_COMBINED_PROCESS_HIGH_ALARM = 3'b010,
        AL_COMBINED_PROCESS_LOW_ALARM = 3'b011,
        AL_DIFFERENCE_HIGH_ALARM = 3'b100,
        AL_DIFFERENCE_LOW_ALARM = 3'b101,
        AL_PROCESS_HIGH = 3'b110,
        AL_PROCESS_LOW = 3'b111
    } sce_alarm_fn_e;

    typedef struct packed {
        sce_pv_src_e process_value_source;
        sce_sp_src_e setpoint_source;
        sce_output_one_function_fn_e output_one_function;
        sce_output_two_function_fn_e output_two_function;
        logic [15:0] proportional_band_one;
        logic [15:0] proportional_band_two;
        logic [15:0] integral_time_one;
        logic [15:0] integral_time_two;
        logic [1:0] input_one_unit;
        logic [1:0] input_two_unit;
        logic [1:0] input_one_decimal_point;
        logic [1:0] input_two_decimal_point;
        sce_alarm_fn_e alarm_one_function;
        sce_alarm_fn_e alarm_two_function;
    } sce_setup_s;

    typedef struct packed {
        logic one_both;
        logic two_both;
        logic diff_single;
        logic cooling_output_mode_conflict;
        logic unit_mismatch;
        logic alarm_none;
        logic dwell_both;
    } sce_setup_err_s;

    // ----------------------------------------------------------------
    // Communication request and answer
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] data;
    } sce_comm_req_s;

    typedef struct packed {
        logic valid;
        logic [7:0] err;
        logic wr_en;
        logic [15:0] wr_addr;
        logic [15:0] wr_data;
    } sce_comm_rsp_s;

    // ----------------------------------------------------------------
    // Module state
    // ----------------------------------------------------------------
    typedef struct packed {
        sce_comm_rsp_s rsp;
        logic [7:0] last_err;
    } sce_comm_state_s;

    typedef struct packed {
        sce_setup_err_s err;
        logic [7:0] code;
        logic output_two_function_alarm;
    } sce_top_state_s;

endpackage

// ---- test/sce_comm_master.sv ----
// Remote master model that presents register requests to the checker
`timescale 1ns/10ps
`default_nettype none
module sce_comm_master (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [7:0] func_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] data_i,
    output sce_pkg::sce_comm_req_s req_o
);
    logic [39:0] last_q = '0;
    always_ff @(posedge clk_i) begin
        if (go_i) begin
            last_q <= {func_i, addr_i, data_i};
        end
    end
    // Idle fields show the inverse of the last request so stale values never pass
    // Faulty requests go out only when the bench commands them
    assign req_o = go_i ? {1'b1, func_i, addr_i, data_i} : {1'b0, ~last_q};
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Randomised self-checking bench for the setup and communication checker
`timescale 1ns/10ps
`default_nettype none
`include "sce_cfg.svh"
module tb;
    logic CLK_I = 1'b0, SRST_I = 1'b1, ACT_I = 1'b0, LOCK_I = 1'b0, CLR_I = 1'b0, GO = 1'b0;
    logic [7:0] FN = 8'h00;
    logic [15:0] AD = 16'h0000, DT = 16'h0000;
    sce_pkg::sce_setup_s SETUP_I = '0;
    sce_pkg::sce_comm_req_s REQ;
    sce_pkg::sce_setup_err_s ERR_O, e;
    sce_pkg::sce_comm_rsp_s RSP_O;
    logic [7:0] CODE_O, LAST_O, ce, le = 8'h00;
    logic OUTPUT_TWO_FUNCTION_O;
    int err_total = 0, comparisons = 0;
    logic [7:0] ftab [4] = '{8'h03, 8'h06, 8'h06, 8'h00};
    logic [15:0] dtab [4] = '{16'h270F, 16'h2710, 16'h0000, 16'hFFFF};

    always #12.5 CLK_I = ~CLK_I;

    sce_comm_master i_mst (.clk_i(CLK_I), .go_i(GO), .func_i(FN), .addr_i(AD), .data_i(DT), .req_o(REQ));
    sce_checker i_dut (.CLK_I(CLK_I), .SRST_I(SRST_I), .SETUP_I(SETUP_I), .ALARM_TWO_ACTIVE_I(ACT_I),
        .COMM_REQ_I(REQ), .PARAM_LOCK_I(LOCK_I), .COMM_ERR_CLR_I(CLR_I), .SETUP_ERR_O(ERR_O),
        .SETUP_ERR_CODE_O(CODE_O), .OUTPUT_TWO_FUNCTION_ALARM_O(OUTPUT_TWO_FUNCTION_O), .COMM_RSP_O(RSP_O), .COMM_LAST_ERR_O(LAST_O));

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    function automatic sce_pkg::sce_setup_err_s exp_err(input sce_pkg::sce_setup_s s);
        sce_pkg::sce_setup_err_s r;
        logic comb;
        r.one_both = s.process_value_source == 2'b00 && s.setpoint_source == 2'b01;
        r.two_both = s.process_value_source == 2'b01 && s.setpoint_source == 2'b10;
        r.diff_single = s.process_value_source[1] && s.setpoint_source inside {2'b01, 2'b10};
        r.cooling_output_mode_conflict = s.output_two_function == 2'b01 && (s.output_one_function == 1'b1 ||
            ((s.proportional_band_one == 0 || s.proportional_band_two == 0) &&
             (s.integral_time_one == 0 || s.integral_time_two == 0)));
        comb = s.process_value_source[1] || s.setpoint_source inside {2'b01, 2'b10} ||
            s.alarm_one_function inside {[3'b010:3'b101]} || s.alarm_two_function inside {[3'b010:3'b101]};
        r.unit_mismatch = comb && (s.input_one_unit != s.input_two_unit ||
            s.input_one_decimal_point != s.input_two_decimal_point);
        r.alarm_none = s.output_two_function == 2'b10 && s.alarm_two_function == 3'b000;
        r.dwell_both = s.alarm_one_function == 3'b001 && s.alarm_two_function == 3'b001;
        return r;
    endfunction

    function automatic logic [7:0] exp_cerr(input logic [7:0] f, input logic [15:0] a, d, input logic lk);
        logic [63:0] ex = `SCE_EXIST_MASK, ro = `SCE_RO_MASK;
        if (f != `SCE_FC_READ && f != `SCE_FC_WRITE) return `SCE_ERR_BAD_FUNC;
        if (a >= `SCE_REG_COUNT) return `SCE_ERR_ADDR_RANGE;
        if (!ex[a[5:0]]) return `SCE_ERR_NO_PARAM;
        if (f == `SCE_FC_WRITE && (ro[a[5:0]] || lk)) return `SCE_ERR_READ_ONLY;
        if (f == `SCE_FC_WRITE && (d < `SCE_VAL_MIN || d > `SCE_VAL_MAX)) return `SCE_ERR_VALUE_RANGE;
        return `SCE_ERR_NONE;
    endfunction

    initial begin
        #(25ns * 3000);
        err_total++;
        print_verdict();
    end

    initial begin
        sce_pkg::sce_setup_s ps;
        sce_pkg::sce_setup_s ns;
        logic pa, pg, pl, pc, pr;
        logic [7:0] pf, code;
        logic [15:0] pad, pd;
        ps = '0; {pa, pg, pl, pc, pr, pf, pad, pd} = '0;
        void'($urandom(84));
        repeat (2) @(posedge CLK_I);
        SRST_I <= 1'b0;
        for (int i = 0; i < 2000; i++) begin
            @(posedge CLK_I);
            ns = SETUP_I;
            // Every 50 cycles a clean setup is held for four cycles so conflicts are seen to clear
            if (i % 50 == 0) begin
                ns = '0;
                ns.process_value_source = sce_pkg::PV_INPUT_TWO_VALUE;
            end else if (i % 50 > 3) begin
                ns = 85'({$urandom, $urandom, $urandom});
                ns.proportional_band_one = 16'($urandom_range(0, 1));
                ns.proportional_band_two = 16'($urandom_range(0, 1));
                ns.integral_time_one = 16'($urandom_range(0, 1));
                ns.integral_time_two = 16'($urandom_range(0, 1));
                ns.input_one_unit = 2'($urandom_range(0, 1));
                ns.input_one_decimal_point = 2'($urandom_range(0, 1));
            end
            SETUP_I <= ns;
            // One reset pulse in mid-run must clear every output
            SRST_I <= (i == 1000);
            ACT_I <= 1'($urandom_range(0, 1));
            GO <= 1'($urandom_range(0, 1));
            FN <= (i % 3 == 0) ? 8'($urandom) : ftab[$urandom_range(0, 3)];
            AD <= (i % 5 == 0) ? 16'($urandom) : 16'($urandom_range(50, 66));
            DT <= (i % 2 == 0) ? dtab[$urandom_range(0, 3)] : 16'($urandom_range(0, 16'h2800));
            LOCK_I <= $urandom_range(0, 7) == 0;
            CLR_I <= $urandom_range(0, 5) == 0;
            @(negedge CLK_I);
            if (pr) begin
                e = '0;
            end else begin
                e = exp_err(ps);
            end
            code = 8'h00;
            for (int b = 0; b < 7; b++) if (code == 8'h00 && e[6-b]) code = 8'(b + 1);
            chk(ERR_O.one_both, e.one_both);
            chk(ERR_O.two_both, e.two_both);
            chk(ERR_O.diff_single, e.diff_single);
            chk(ERR_O.cooling_output_mode_conflict, e.cooling_output_mode_conflict);
            chk(ERR_O.unit_mismatch, e.unit_mismatch);
            chk(ERR_O.alarm_none, e.alarm_none);
            chk(ERR_O.dwell_both, e.dwell_both);
            chk(CODE_O, code);
            if (e.alarm_none) chk(OUTPUT_TWO_FUNCTION_O, 1'b0);
            chk(OUTPUT_TWO_FUNCTION_O, !pr && pa && ps.output_two_function == 2'b10 && ps.alarm_two_function != 3'b000);
            ce = exp_cerr(pf, pad, pd, pl);
            pg = pg && !pr;
            chk(RSP_O.valid, pg);
            if (pg) chk(RSP_O.err, ce);
            chk(RSP_O.wr_en, pg && pf == `SCE_FC_WRITE && ce == 8'h00);
            if (pg && pf == `SCE_FC_WRITE && ce == 8'h00) chk({RSP_O.wr_addr, RSP_O.wr_data}, {pad, pd});
            if (pr) le = 8'h00;
            else if (pg && ce != 8'h00) le = ce;
            else if (pc) le = 8'h00;
            chk(LAST_O, le);
            ps = SETUP_I; pa = ACT_I; pg = GO; pf = FN; pad = AD; pd = DT; pl = LOCK_I; pc = CLR_I;
            pr = SRST_I;
        end
        print_verdict();
    end
endmodule
`default_nettype wire
